// ---- ephy_phy_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ephy_phy_model
  import ephy_pkg::*;
(
  // Device side
  input  wire ephy_mode_type mode_i,
  input  wire logic          ref_i,
  input  wire logic [3:0]    txd_i,
  input  wire logic          transmit_enable_out_i,
  // PHY outputs
  output logic               txc_o,
  output logic               rxc_o,
  output logic      [3:0]    rxd_o,
  output logic               dv_o,
  output logic               er_o,
  output logic               col_o,
  output logic               crs_o
);
  wire logic  mii = mode_i != EPHY_RMII;
  logic [8:0] got[$];
  logic [7:0] sh = 8'h00;
  int         n = 0;
  logic       col_req = 1'b0;

  assign col_o = col_req;
  assign crs_o = col_req | (mii & dv_o);
  // MII clocks run free, held low by pull-downs in RMII
  initial begin
    {txc_o, rxc_o, dv_o, er_o, rxd_o} = 8'h0c;
    fork
      begin #3; forever #20 txc_o = ~txc_o & mii; end
      begin #11; forever #20 rxc_o = ~rxc_o & mii; end
    join_none
  end
  // Low unit first; enable drop marks the frame end
  task automatic take(input logic [3:0] u, input int w);
    if (transmit_enable_out_i === 1'b1) begin
      sh = (w == 4) ? {u, sh[7:4]} : {u[1:0], sh[7:2]};
      n = n + w;
      if (n == 8) begin
        got.push_back({1'b0, sh});
        n = 0;
      end
    end else begin
      if (got.size() != 0) got[$][8] = 1'b1;
      n = 0;
    end
  endtask
  always @(posedge txc_o) if (mii) take(txd_i, 4);
  always @(negedge ref_i) if (!mii) take(txd_i, 2);
  // Idle rxd_o[1:0] lines never hold a stale unit; rxd_o[3:2] keep their value
  always @(posedge rxc_o, negedge ref_i) if (!dv_o) rxd_o[1:0] <= ~rxd_o[1:0];

  task automatic tick();
    if (mii) @(negedge rxc_o);
    else @(posedge ref_i);
  endtask
  task automatic rx_frame(input logic [7:0] q[$], input int bad);
    int         w;
    logic [7:0] b;
    w = mii ? 4 : 2;
    for (int i = 0; i < q.size() * 8 / w; i++) begin
      tick();
      b = q[i * w / 8] >> (i * w % 8);
      if (mii) rxd_o = b[3:0];
      else rxd_o[1:0] = b[1:0];
      dv_o = 1'b1;
      er_o = (i == bad);
    end
    tick();
    dv_o = 1'b0;
    er_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- ephy_pkg.sv ----
`default_nettype none
package ephy_pkg;
  // ----------------------------------------
  // Clock and reference divider
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ  = 125_000_000;
  localparam int unsigned MII_REF_HZ   = 25_000_000;
  localparam int unsigned REF_DIV      = CLK_FREQ_HZ / MII_REF_HZ;
  localparam logic [2:0]  REF_CNT_LAST = 3'(REF_DIV - 1);
  localparam logic [2:0]  REF_CNT_ZERO = 3'h0;
  // MII: high while count below this
  localparam logic [2:0]  REF_MII_HIGH = 3'h2;
  // RMII: second high phase of the 5-cycle pattern
  localparam logic [2:0]  REF_RMII_HI2 = 3'h2;

  // ----------------------------------------
  // Lane layout
  // ----------------------------------------
  localparam logic [1:0]  MII_UNIT_LAST  = 2'h1;
  localparam logic [1:0]  RMII_UNIT_LAST = 2'h3;
  localparam logic [1:0]  UNIT_ZERO      = 2'h0;
  localparam logic [3:0]  TXD_RESET      = 4'h0;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam int unsigned TXF_DEPTH      = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {EPHY_MII, EPHY_RMII, EPHY_FMII} ephy_mode_type;
  typedef enum logic {TX_IDLE, TX_SEND} ephy_txst_type;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } ephy_txw_type;

  typedef struct packed {
    logic [3:0] rxd;
    logic       dv;
    logic       er;
    logic       txc;
    logic       rxc;
    logic       col;
    logic       crs;
    logic       link;
    logic       mdi;
  } ephy_pins_type;

  // Link pin idles high on its pull-up; no false toggle after reset
  localparam ephy_pins_type PINS_RESET = '{link: 1'b1, default: '0};
endpackage
`default_nettype wire

// ---- ephy_top.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module ephy_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr_reg  <= wr_ptr_reg + AW'(push);
      rd_ptr_reg  <= rd_ptr_reg + AW'(pop);
      count_reg   <= count_next;
      in_ready_o  <= (count_next != CNT_FULL);
      out_valid_o <= (count_next != '0);
    end
  end
endmodule

// ----------------------------------------
// PHY pin attachment
// ----------------------------------------
module ephy_top
  import ephy_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // Configuration
  input  wire ephy_mode_type mode_i,
  // Transmit stream
  input  wire logic [7:0]    tx_data_i,
  input  wire logic          tx_last_i,
  input  wire logic          tx_valid_i,
  output logic               tx_ready_o,
  // Receive stream
  output logic      [7:0]    rx_data_o,
  output logic               rx_valid_o,
  output logic               rx_last_o,
  output logic               rx_error_o,
  // Line status
  output logic               rmii_speed_100_o,
  output logic               rmii_link_o,
  output logic               link_level_o,
  output logic               link_activity_o,
  output logic               col_o,
  output logic               crs_o,
  // Management user side
  input  wire logic          mgmt_mdc_i,
  input  wire logic          mgmt_mdo_i,
  input  wire logic          mgmt_mdo_oe_i,
  output logic               mgmt_mdi_o,
  // PHY transmit pins
  output logic      [3:0]    txd_o,
  output logic               transmit_enable_out_o,
  input  wire logic          txc_i,
  // PHY receive pins
  input  wire logic [3:0]    rxd_i,
  input  wire logic          receive_valid_in_i,
  input  wire logic          receive_error_in_i,
  input  wire logic          rxc_i,
  input  wire logic          col_i,
  input  wire logic          crs_i,
  input  wire logic          link_i,
  // PHY management and clock pins
  output logic               mdc_o,
  output logic               mdio_o,
  output logic               mdio_oe_o,
  input  wire logic          mdio_i,
  output logic               phy_ref_clock_out_o
);
  logic          rst_meta_reg;
  logic          rst_n;
  ephy_pins_type pins_raw;
  ephy_pins_type pins_meta_reg;
  ephy_pins_type pins_sync_reg;
  ephy_pins_type pins_prev_reg;
  logic          is_rmii;
  logic [2:0]    ref_cnt_reg;
  logic          ref_high;
  logic          ref_rise;
  logic [1:0]    ref_rise_dly_reg;
  logic [1:0]    unit_last;
  ephy_txw_type  fifo_in;
  ephy_txw_type  fifo_out;
  logic          fifo_valid;
  logic          fifo_pop;
  logic          tx_tick;
  ephy_txst_type tx_state_reg;
  logic [7:0]    tx_byte_reg;
  logic [1:0]    tx_unit_reg;
  logic          tx_gap_reg;
  logic          rx_tick;
  logic [7:0]    rx_shift_reg;
  logic [7:0]    rx_byte_next;
  logic [1:0]    rx_unit_reg;
  logic [7:0]    rx_pend_reg;
  logic          rx_pend_valid_reg;
  logic          rx_err_acc_reg;

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  assign pins_raw = '{rxd: rxd_i, dv: receive_valid_in_i, er: receive_error_in_i,
                      txc: txc_i, rxc: rxc_i, col: col_i, crs: crs_i,
                      link: link_i, mdi: mdio_i};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta_reg <= PINS_RESET;
      pins_sync_reg <= PINS_RESET;
      pins_prev_reg <= PINS_RESET;
    end else begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  assign is_rmii   = (mode_i == EPHY_RMII);
  assign unit_last = is_rmii ? RMII_UNIT_LAST : MII_UNIT_LAST;

  // ----------------------------------------
  // Reference clock from system clock
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg <= REF_CNT_ZERO;
    end else if (ref_cnt_reg == REF_CNT_LAST) begin
      ref_cnt_reg <= REF_CNT_ZERO;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 1'b1;
    end
  end

  // Outside MII mode, two pulses per five cycles give a 50 MHz average; MII gets one two-cycle pulse (25 MHz)
  assign ref_high = (mode_i == EPHY_MII) ? (ref_cnt_reg < REF_MII_HIGH) :
                    (ref_cnt_reg == REF_CNT_ZERO) || (ref_cnt_reg == REF_RMII_HI2);
  assign ref_rise = ref_high & ~phy_ref_clock_out_o;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phy_ref_clock_out_o <= 1'b0;
      ref_rise_dly_reg    <= 2'h0;
    end else begin
      phy_ref_clock_out_o <= ref_high;
      ref_rise_dly_reg    <= {ref_rise_dly_reg[0], ref_rise};
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  assign fifo_in = '{last: tx_last_i, data: tx_data_i};

  ephy_fifo #(
    .WIDTH ($bits(ephy_txw_type)),
    .DEPTH (TXF_DEPTH)
  ) u_txf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_data_i   (fifo_in),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  assign tx_tick  = is_rmii ? ref_rise :
                    (pins_sync_reg.txc & ~pins_prev_reg.txc);
  assign fifo_pop = tx_tick & (tx_unit_reg == UNIT_ZERO) & ~tx_gap_reg & fifo_valid;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg          <= TX_IDLE;
      tx_byte_reg           <= BYTE_RESET;
      tx_unit_reg           <= UNIT_ZERO;
      tx_gap_reg            <= 1'b0;
      txd_o                 <= TXD_RESET;
      transmit_enable_out_o <= 1'b0;
    end else if (tx_tick) begin
      if (tx_unit_reg != UNIT_ZERO) begin
        tx_unit_reg <= tx_unit_reg - 1'b1;
        if (is_rmii) begin
          txd_o       <= {2'h0, tx_byte_reg[1:0]};
          tx_byte_reg <= {2'h0, tx_byte_reg[7:2]};
        end else begin
          txd_o       <= tx_byte_reg[3:0];
          tx_byte_reg <= {4'h0, tx_byte_reg[7:4]};
        end
      end else if (fifo_pop) begin
        tx_state_reg          <= TX_SEND;
        transmit_enable_out_o <= 1'b1;
        tx_unit_reg           <= unit_last;
        tx_gap_reg            <= fifo_out.last;
        if (is_rmii) begin
          txd_o       <= {2'h0, fifo_out.data[1:0]};
          tx_byte_reg <= {2'h0, fifo_out.data[7:2]};
        end else begin
          txd_o       <= fifo_out.data[3:0];
          tx_byte_reg <= {4'h0, fifo_out.data[7:4]};
        end
      end else begin
        tx_state_reg          <= TX_IDLE;
        transmit_enable_out_o <= 1'b0;
        txd_o                 <= TXD_RESET;
        tx_gap_reg            <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  assign rx_tick = is_rmii ? ref_rise_dly_reg[1] :
                   (pins_sync_reg.rxc & ~pins_prev_reg.rxc);

  always_comb begin
    if (is_rmii) begin
      rx_byte_next = {pins_sync_reg.rxd[1:0], rx_shift_reg[7:2]};
    end else begin
      rx_byte_next = {pins_sync_reg.rxd, rx_shift_reg[7:4]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg      <= BYTE_RESET;
      rx_unit_reg       <= UNIT_ZERO;
      rx_pend_reg       <= BYTE_RESET;
      rx_pend_valid_reg <= 1'b0;
      rx_err_acc_reg    <= 1'b0;
      rx_data_o         <= BYTE_RESET;
      rx_valid_o        <= 1'b0;
      rx_last_o         <= 1'b0;
      rx_error_o        <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (rx_tick && pins_sync_reg.dv) begin
        rx_shift_reg   <= rx_byte_next;
        rx_err_acc_reg <= rx_err_acc_reg | pins_sync_reg.er;
        if (rx_unit_reg == unit_last) begin
          rx_unit_reg       <= UNIT_ZERO;
          rx_pend_reg       <= rx_byte_next;
          rx_pend_valid_reg <= 1'b1;
          if (rx_pend_valid_reg) begin
            rx_data_o  <= rx_pend_reg;
            rx_valid_o <= 1'b1;
            rx_last_o  <= 1'b0;
            rx_error_o <= 1'b0;
          end
        end else begin
          rx_unit_reg <= rx_unit_reg + 1'b1;
        end
      end else if (rx_tick) begin
        rx_unit_reg       <= UNIT_ZERO;
        rx_pend_valid_reg <= 1'b0;
        rx_err_acc_reg    <= 1'b0;
        if (rx_pend_valid_reg) begin
          rx_data_o  <= rx_pend_reg;
          rx_valid_o <= 1'b1;
          rx_last_o  <= 1'b1;
          rx_error_o <= rx_err_acc_reg;
        end
      end
    end
  end

  // ----------------------------------------
  // Status and management
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rmii_speed_100_o <= 1'b0;
      rmii_link_o      <= 1'b0;
      link_level_o     <= 1'b0;
      link_activity_o  <= 1'b0;
      col_o            <= 1'b0;
      crs_o            <= 1'b0;
      mdc_o            <= 1'b0;
      mdio_o           <= 1'b0;
      mdio_oe_o        <= 1'b0;
      mgmt_mdi_o       <= 1'b0;
    end else begin
      rmii_speed_100_o <= is_rmii & pins_sync_reg.rxd[2];
      rmii_link_o      <= is_rmii & pins_sync_reg.rxd[3];
      link_level_o     <= pins_sync_reg.link;
      link_activity_o  <= pins_sync_reg.link ^ pins_prev_reg.link;
      col_o            <= ~is_rmii & pins_sync_reg.col;
      crs_o            <= ~is_rmii & pins_sync_reg.crs;
      mdc_o            <= mgmt_mdc_i;
      mdio_o           <= mgmt_mdo_i;
      mdio_oe_o        <= mgmt_mdo_oe_i;
      mgmt_mdi_o       <= pins_sync_reg.mdi;
    end
  end
endmodule
`default_nettype wire

// ---- ephy_top_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ephy_top_checker
  import ephy_pkg::*;
(
  // Watched ports
  input wire logic          clk_i,
  input wire logic          rstn_i,
  input wire ephy_mode_type mode_i,
  input wire logic [3:0]    txd_o,
  input wire logic          transmit_enable_out_o,
  input wire logic          phy_ref_clock_out_o,
  input wire logic          mdio_i,
  input wire logic          mgmt_mdi_o,
  input wire logic          col_o,
  input wire logic          crs_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_two_high; phy_ref_clock_out_o [*2]; endsequence
  sequence s_three_low; !phy_ref_clock_out_o [*3]; endsequence

  property p_ref_rst;
    disable iff (1'b0) !rstn_i |-> !phy_ref_clock_out_o;
  endproperty
  a_ref_rst: assert property (p_ref_rst) else $error("ref clock high in reset");
  property p_tx_rst;
    disable iff (1'b0) !rstn_i |-> txd_o == 4'h0 && !transmit_enable_out_o;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx pins active in reset");
  property p_tx_idle;
    !transmit_enable_out_o |-> txd_o == 4'h0;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx data without enable");
  property p_rmii_upper;
    mode_i == EPHY_RMII |-> txd_o[3:2] == 2'h0;
  endproperty
  a_rmii_upper: assert property (p_rmii_upper) else $error("upper tx lines used");
  property p_ref_mii;
    mode_i == EPHY_MII && $rose(phy_ref_clock_out_o)
      |-> s_two_high ##1 s_three_low ##1 phy_ref_clock_out_o;
  endproperty
  a_ref_mii: assert property (p_ref_mii) else $error("ref clock not 25 MHz");
  property p_ref_fast;
    mode_i != EPHY_MII && $rose(phy_ref_clock_out_o)
      |=> !phy_ref_clock_out_o ##[1:2] phy_ref_clock_out_o;
  endproperty
  a_ref_fast: assert property (p_ref_fast) else $error("ref clock not 50 MHz");
  property p_mdi_delay;
    $past(rstn_i, 6) |-> mgmt_mdi_o == $past(mdio_i, 3);
  endproperty
  a_mdi_delay: assert property (p_mdi_delay) else $error("mdio input lost");
  property p_rmii_ignore;
    mode_i == EPHY_RMII |-> !col_o && !crs_o;
  endproperty
  a_rmii_ignore: assert property (p_rmii_ignore) else $error("col or crs used");
endmodule

bind ephy_top ephy_top_checker ephy_top_checker_i (
  .clk_i, .rstn_i, .mode_i, .txd_o, .transmit_enable_out_o, .phy_ref_clock_out_o,
  .mdio_i, .mgmt_mdi_o, .col_o, .crs_o
);
`default_nettype wire

// ---- tb_ephy_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_ephy_top
  import ephy_pkg::*;
;
  logic          clk_i = 1'b0, rstn_i = 1'b1, saw_full = 1'b0;
  ephy_mode_type mode_i = EPHY_MII;
  logic [7:0]    tx_data_i = 8'h00, rx_data_o, acts = 8'h00;
  logic          tx_last_i = 1'b0, tx_valid_i = 1'b0, link_i = 1'b1, phy_mdio = 1'b0;
  logic          mgmt_mdc_i = 1'b1, mgmt_mdo_i = 1'b0, mgmt_mdo_oe_i = 1'b0;
  logic [3:0]    txd_o, rxd_i;
  logic          tx_ready_o, rx_valid_o, rx_last_o, rx_error_o, rmii_speed_100_o, rmii_link_o;
  logic          link_level_o, link_activity_o, col_o, crs_o, mgmt_mdi_o, transmit_enable_out_o;
  logic          txc_i, rxc_i, receive_valid_in_i, receive_error_in_i, col_i, crs_i;
  logic          mdc_o, mdio_o, mdio_oe_o, phy_ref_clock_out_o;
  wire logic     mdio_i = mdio_oe_o ? mdio_o : phy_mdio;
  int            fails = 0, checks = 0, cyc = 0;
  logic [9:0]    exp_rx[$];
  logic [8:0]    exp_tx[$];
  ephy_mode_type modes[3] = '{EPHY_MII, EPHY_RMII, EPHY_FMII};

  ephy_top ephy_top_i (
    .clk_i, .rstn_i, .mode_i, .tx_data_i, .tx_last_i, .tx_valid_i, .tx_ready_o, .rx_data_o,
    .rx_valid_o, .rx_last_o, .rx_error_o, .rmii_speed_100_o, .rmii_link_o, .link_level_o,
    .link_activity_o, .col_o, .crs_o, .mgmt_mdc_i, .mgmt_mdo_i, .mgmt_mdo_oe_i, .mgmt_mdi_o,
    .txd_o, .transmit_enable_out_o, .txc_i, .rxd_i, .receive_valid_in_i, .receive_error_in_i,
    .rxc_i, .col_i, .crs_i, .link_i, .mdc_o, .mdio_o, .mdio_oe_o, .mdio_i, .phy_ref_clock_out_o
  );
  ephy_phy_model ephy_phy_model_i (
    .mode_i, .ref_i(phy_ref_clock_out_o), .txd_i(txd_o), .transmit_enable_out_i(transmit_enable_out_o),
    .txc_o(txc_i), .rxc_o(rxc_i), .rxd_o(rxd_i), .dv_o(receive_valid_in_i),
    .er_o(receive_error_in_i), .col_o(col_i), .crs_o(crs_i)
  );

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Every received byte against the expected queue
  always @(negedge clk_i) begin
    if (link_activity_o === 1'b1) acts++;
    if (rx_valid_o === 1'b1) begin
      chk({rx_last_o, rx_data_o}, exp_rx[0][8:0]);
      if (rx_last_o === 1'b1) chk(rx_error_o, exp_rx[0][9]);
      void'(exp_rx.pop_front());
    end
  end

  task automatic restart(input ephy_mode_type m);
    rstn_i = 1'b0;
    mode_i = m;
    ephy_phy_model_i.rxd_o[3:2] = 2'b11;
    repeat (4) @(negedge clk_i);
    chk({mdc_o, phy_ref_clock_out_o, transmit_enable_out_o, txd_o}, 16'h0000);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(tx_ready_o, 1'b1);
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    tx_data_i = d;
    tx_last_i = l;
    tx_valid_i = 1'b1;
    while (tx_ready_o !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge clk_i);
    end
    @(negedge clk_i);
  endtask
  task automatic send_tx(input int len);
    logic [7:0] d;
    for (int i = 0; i < len; i++) begin
      d = 8'($urandom);
      exp_tx.push_back({i == len - 1, d});
      push(d, i == len - 1);
    end
    tx_valid_i = 1'b0;
    for (int k = 0; k < 3000 && ephy_phy_model_i.got.size() < exp_tx.size(); k++)
      @(negedge clk_i);
    repeat (20) @(negedge clk_i);
    chk(16'(ephy_phy_model_i.got.size()), 16'(exp_tx.size()));
    foreach (exp_tx[i]) chk(ephy_phy_model_i.got[i], exp_tx[i]);
    exp_tx.delete();
    ephy_phy_model_i.got.delete();
  endtask
  task automatic send_rx(input int len, input int bad);
    logic [7:0] q[$];
    for (int i = 0; i < len; i++) begin
      q.push_back(8'($urandom));
      exp_rx.push_back({bad >= 0, i == len - 1, q[i]});
    end
    ephy_phy_model_i.rx_frame(q, bad);
    repeat (20) @(negedge clk_i);
    chk(16'(exp_rx.size()), 16'h0000);
  endtask

  initial begin
    logic [2:0] r;
    void'($urandom(54));
    #1;
    foreach (modes[k]) begin
      restart(modes[k]);
      send_tx(24);
      send_rx(6, -1);
      send_rx(5, $urandom_range(0, 9));
      ephy_phy_model_i.col_req = 1'b1;
      repeat (6) @(negedge clk_i);
      chk({col_o, crs_o}, (modes[k] == EPHY_RMII) ? 2'b00 : 2'b11);
      ephy_phy_model_i.col_req = 1'b0;
    end
    restart(EPHY_RMII);
    for (int s = 0; s < 4; s++) begin
      ephy_phy_model_i.rxd_o[3:2] = 2'(s);
      repeat (6) @(negedge clk_i);
      chk({rmii_link_o, rmii_speed_100_o}, 16'(s));
    end
    chk(saw_full, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = 3'($urandom);
      {mgmt_mdc_i, mgmt_mdo_i, mgmt_mdo_oe_i} = r;
      phy_mdio = r[0] ^ r[2];
      @(negedge clk_i);
      chk({mdc_o, mdio_o, mdio_oe_o}, r);
    end
    repeat (4) @(negedge clk_i);
    chk(mgmt_mdi_o, mdio_i);
    for (int i = 0; i < 4; i++) begin
      link_i = ~link_i;
      repeat (6) @(negedge clk_i);
    end
    chk({acts, link_level_o}, {8'h04, link_i});
    tally_and_finish();
  end
endmodule
`default_nettype wire
